// ### core/zvscfg_map.svh
// Register offsets, field positions, reset values and timing counts
`ifndef ZVSCFG_MAP_SVH
`define ZVSCFG_MAP_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ZVSCFG_ADDR_VOLT_SET 8'h02
`define ZVSCFG_ADDR_CURR_SET 8'h04
`define ZVSCFG_ADDR_OV_THR 8'h06
`define ZVSCFG_ADDR_UV_THR 8'h08
`define ZVSCFG_ADDR_POWER_THR 8'h0A
`define ZVSCFG_ADDR_FAULT_TMR 8'h0C
`define ZVSCFG_ADDR_CTRL_BITS 8'h0E
`define ZVSCFG_ADDR_MEAS_CURR 8'h10
`define ZVSCFG_ADDR_MEAS_VOLT 8'h12
`define ZVSCFG_ADDR_ZVS_CFG 8'h3E

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define ZVSCFG_FWD_BIT 11
`define ZVSCFG_SOFT_BIT 10
`define ZVSCFG_DLY_MSB 7
`define ZVSCFG_DLY_LSB 5
`define ZVSCFG_ON_MSB 4
`define ZVSCFG_ON_LSB 0
`define ZVSCFG_ZVS_RESET 16'h0000
`define ZVSCFG_READ_ZERO 16'h0000

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define ZVSCFG_STEP_NS 85
`define ZVSCFG_CLK_MHZ 200
`define ZVSCFG_STEP_CYC ((`ZVSCFG_STEP_NS * `ZVSCFG_CLK_MHZ + 999) / 1000)

`endif

// ### core/zvscfg_pkg.sv
// Types shared by the soft-switching config and read-back bank
package zvscfg_pkg;
   typedef enum logic [1:0] {ZVS_IDLE, ZVS_DELAY, ZVS_ON} zvscfg_state_e;
   typedef logic [15:0] zvscfg_word_t;
endpackage : zvscfg_pkg

// ### core/zvscfg_timer.sv
// Delay-then-on interval generator for rectifier soft switching
`timescale 1ns/1ps
`default_nettype none
`include "zvscfg_map.svh"

module zvscfg_timer
(
   input wire logic clock,
   input wire logic rst_b,
   input wire logic enable,
   input wire logic trigger,
   input wire logic [2:0] delay_count,
   input wire logic [4:0] on_count,
   output logic drive
);

   localparam logic [4:0] STEP_LAST = 5'(`ZVSCFG_STEP_CYC - 1);

   zvscfg_pkg::zvscfg_state_e state;
   zvscfg_pkg::zvscfg_state_e next_state;
   logic [4:0] tick;
   logic [4:0] next_tick;
   logic [4:0] steps;
   logic [4:0] next_steps;
   logic next_drive;

   // ----------------------------------------------------------------
   // Sequencer: each count step lasts one 85 ns tick
   // ----------------------------------------------------------------
   always_comb
   begin
      next_state = state;
      next_tick = tick;
      next_steps = steps;
      unique case (state)
         zvscfg_pkg::ZVS_IDLE:
         begin
            next_tick = 5'h00;
            if (enable && trigger)
            begin
               next_state = zvscfg_pkg::ZVS_DELAY;
               next_steps = {2'b00, delay_count};
            end
         end
         zvscfg_pkg::ZVS_DELAY, zvscfg_pkg::ZVS_ON:
         begin
            if (steps == 5'h00)
            begin
               // Zero steps ends the phase at once
               next_tick = 5'h00;
               if (state == zvscfg_pkg::ZVS_DELAY)
               begin
                  next_state = zvscfg_pkg::ZVS_ON;
                  next_steps = on_count;
               end
               else
               begin
                  next_state = zvscfg_pkg::ZVS_IDLE;
               end
            end
            else if (tick == STEP_LAST)
            begin
               next_tick = 5'h00;
               next_steps = steps - 5'h01;
            end
            else
            begin
               next_tick = tick + 5'h01;
            end
         end
      endcase
      // Dropping the enable aborts a sequence in flight
      if (!enable)
      begin
         next_state = zvscfg_pkg::ZVS_IDLE;
      end
      next_drive = (next_state == zvscfg_pkg::ZVS_ON);
   end

   // Registers only
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state <= zvscfg_pkg::ZVS_IDLE;
         tick <= 5'h00;
         steps <= 5'h00;
         drive <= 1'b0;
      end
      else
      begin
         state <= next_state;
         tick <= next_tick;
         steps <= next_steps;
         drive <= next_drive;
      end
   end

endmodule : zvscfg_timer

`default_nettype wire

// ### core/zvscfg_bank.sv
// Soft-switching config register, fault response and telemetry read-back
//
// How it works
// - Config bit 11 high enables forward valley switching; low disables it.
// - Rectifier soft-switch mode runs only while config bit 10 is high.
// - Every count step adds about 85 ns to its interval.
// - Fault with fault response disabled drops bus switch enable and resets.
// - That reset may request auto-restart depending on operating conditions.
// - Telemetry words are 16 bits; some carry high and low byte parity.
`timescale 1ns/1ps
`default_nettype none
`include "zvscfg_map.svh"

module zvscfg_bank
(
   input wire logic clock,
   input wire logic rst_b,

   // Register port from the serial engine
   input wire logic wr_en,
   input wire logic [7:0] wr_addr,
   input wire logic [15:0] wr_data,
   input wire logic rd_en,
   input wire logic [7:0] rd_addr,
   output logic [15:0] rd_data,
   output logic rd_valid,

   // Accepted command values
   // Levels, only sampled by a read; bus_switch_enable_bit also gates the bus switch
   input wire logic [11:0] voltage_setpoint_field,
   input wire logic [7:0] current_setpoint_field,
   input wire logic [11:0] overvoltage_threshold_field,
   input wire logic [11:0] undervoltage_threshold_field,
   input wire logic [8:0] power_limit_field,
   input wire logic [1:0] overvoltage_action,
   input wire logic [1:0] undervoltage_action,
   input wire logic [1:0] output_short_action,
   input wire logic [1:0] sense_pin_short_action,
   input wire logic [1:0] undervoltage_timeout,
   input wire logic [1:0] watchdog_timeout,
   input wire logic [1:0] voltage_only_action,
   input wire logic [1:0] voltage_only_timer,
   input wire logic bus_switch_enable_bit,
   input wire logic bleeder_bit,
   input wire logic supply_off_bit,
   input wire logic fast_setpoint_bit,
   input wire logic voltage_only_bit,
   input wire logic thermal_hysteresis_bit,
   input wire logic [3:0] cable_drop_comp_field,

   // Measurements
   // Raw converter codes, unscaled
   input wire logic [7:0] measured_current,
   input wire logic [11:0] measured_voltage,

   // Fault handling
   // A held fault_event counts each cycle
   input wire logic fault_event,
   input wire logic fault_response_disabled,
   input wire logic restart_conditions,

   // Switching
   // Every output leaves a flip-flop
   input wire logic valley_trigger,
   output logic forward_valley,
   output logic rectifier_soft_switch_mode,
   output logic soft_switch_drive,
   output logic bus_switch_enable,
   output logic internal_reset,
   output logic auto_restart
);

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------

   // Odd parity bit over seven data bits
   // A zero byte still shows a set bit
   function automatic logic zvscfg_odd(input logic [6:0] bits);
      zvscfg_odd = ~(^bits);
   endfunction : zvscfg_odd

   // Wrap a word so both bytes carry their own parity bit
   // Raw bits 15 and 7 are overwritten
   function automatic zvscfg_pkg::zvscfg_word_t zvscfg_par
      (input logic [15:0] raw);
      zvscfg_par = {zvscfg_odd(raw[14:8]), raw[14:8],
                    zvscfg_odd(raw[6:0]), raw[6:0]};
   endfunction : zvscfg_par

   // 12-bit value placed at bits 12:8 and 6:0
   // Bit 7 is left for the low parity bit
   function automatic logic [15:0] zvscfg_wide(input logic [11:0] v);
      zvscfg_wide = {3'b000, v[11:7], 1'b0, v[6:0]};
   endfunction : zvscfg_wide

   // ----------------------------------------------------------------
   // Config register
   // ----------------------------------------------------------------
   // Last accepted config word
   zvscfg_pkg::zvscfg_word_t zvs_config;
   zvscfg_pkg::zvscfg_word_t next_zvs_config;
   logic next_forward_valley;
   logic next_soft_mode;

   // Write-only; every write replaces the whole word
   // Reset keeps both modes off until written
   always_comb
   begin
      next_zvs_config = zvs_config;
      if (wr_en && (wr_addr == `ZVSCFG_ADDR_ZVS_CFG))
      begin
         next_zvs_config = wr_data;
      end

      // Enables follow the word written this cycle
      next_forward_valley = next_zvs_config[`ZVSCFG_FWD_BIT];
      next_soft_mode = next_zvs_config[`ZVSCFG_SOFT_BIT];
   end

   // Enables move on the word's own edge
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         zvs_config <= `ZVSCFG_ZVS_RESET;
         forward_valley <= 1'b0;
         rectifier_soft_switch_mode <= 1'b0;
      end
      else
      begin
         zvs_config <= next_zvs_config;
         forward_valley <= next_forward_valley;
         rectifier_soft_switch_mode <= next_soft_mode;
      end
   end

   // ----------------------------------------------------------------
   // Soft-switch interval generator
   // ----------------------------------------------------------------
   // Counts below three are passed through unchanged; the step size
   // is only trustworthy from three upward
   // Enable is the registered mode bit, so a
   // trigger waits one cycle after the write
   // Triggers during a sequence are ignored
   zvscfg_timer u_timer
   (
      .clock(clock),
      .rst_b(rst_b),
      .enable(rectifier_soft_switch_mode),
      .trigger(valley_trigger),
      .delay_count(zvs_config[`ZVSCFG_DLY_MSB:`ZVSCFG_DLY_LSB]),
      .on_count(zvs_config[`ZVSCFG_ON_MSB:`ZVSCFG_ON_LSB]),
      .drive(soft_switch_drive)
   );

   // ----------------------------------------------------------------
   // Fault response
   // ----------------------------------------------------------------
   // Drop latch and pulses that follow the fault
   logic fault_drop;
   logic next_fault_drop;
   logic next_bus_switch_enable;
   logic next_internal_reset;
   logic next_auto_restart;
   logic fault_hit;

   // The drop holds until the host clears its enable bit; a new fault
   // in that same cycle wins so it is never lost
   always_comb
   begin
      fault_hit = fault_event && fault_response_disabled;
      next_fault_drop = fault_drop;

      // Host clears the drop with the bit low
      if (!bus_switch_enable_bit)
      begin
         next_fault_drop = 1'b0;
      end

      // Set after clear: a same-cycle fault wins
      if (fault_hit)
      begin
         next_fault_drop = 1'b1;
      end

      // Restart is only requested here
      next_bus_switch_enable = bus_switch_enable_bit && !next_fault_drop;
      next_internal_reset = fault_hit;
      next_auto_restart = fault_hit && restart_conditions;
   end

   // Registers only; pulses last as many cycles as the fault is held
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         fault_drop <= 1'b0;
         bus_switch_enable <= 1'b0;
         internal_reset <= 1'b0;
         auto_restart <= 1'b0;
      end
      else
      begin
         fault_drop <= next_fault_drop;
         bus_switch_enable <= next_bus_switch_enable;
         internal_reset <= next_internal_reset;
         auto_restart <= next_auto_restart;
      end
   end

   // ----------------------------------------------------------------
   // Telemetry read-back
   // ----------------------------------------------------------------
   // Registered word costs one cycle of
   // latency but leaves a clean flip-flop
   zvscfg_pkg::zvscfg_word_t next_rd_data;
   logic next_rd_valid;

   // Pure multiplexer: a read never disturbs any state
   always_comb
   begin
      next_rd_valid = rd_en;
      next_rd_data = rd_data;
      // Only a strobed read loads the word
      if (rd_en)
      begin
         unique case (rd_addr)
            // Voltage set-point with parity
            `ZVSCFG_ADDR_VOLT_SET:
               next_rd_data =
                  zvscfg_par(zvscfg_wide(voltage_setpoint_field));

            // Current set-point with parity
            `ZVSCFG_ADDR_CURR_SET:
               next_rd_data =
                  zvscfg_par({7'h00, current_setpoint_field[7],
                              1'b0, current_setpoint_field[6:0]});

            // Overvoltage threshold
            `ZVSCFG_ADDR_OV_THR:
               next_rd_data =
                  zvscfg_par(zvscfg_wide(overvoltage_threshold_field));

            // Undervoltage threshold
            `ZVSCFG_ADDR_UV_THR:
               next_rd_data =
                  zvscfg_par(zvscfg_wide(undervoltage_threshold_field));

            // Power limit, no parity
            `ZVSCFG_ADDR_POWER_THR:
               next_rd_data = {7'h00, power_limit_field};

            // Fault actions and timers
            `ZVSCFG_ADDR_FAULT_TMR:
               next_rd_data = {overvoltage_action, undervoltage_action,
                               output_short_action, sense_pin_short_action,
                               undervoltage_timeout, watchdog_timeout,
                               voltage_only_action,
                               voltage_only_timer};

            // Control bits
            `ZVSCFG_ADDR_CTRL_BITS:
               next_rd_data = {1'b0, bus_switch_enable_bit, bleeder_bit,
                               supply_off_bit, fast_setpoint_bit,
                               voltage_only_bit, thermal_hysteresis_bit,
                               5'h00, cable_drop_comp_field};

            // Measured current with parity
            `ZVSCFG_ADDR_MEAS_CURR:
               next_rd_data =
                  zvscfg_par({7'h00, measured_current[7],
                              1'b0, measured_current[6:0]});

            // Measured voltage, top nibble zero
            `ZVSCFG_ADDR_MEAS_VOLT:
               next_rd_data = {4'h0, measured_voltage};

            // Other offsets, odd or even, and the config word
            default:
               next_rd_data = `ZVSCFG_READ_ZERO; // Unmapped or write-only
         endcase
      end
   end

   // Data holds between reads for a slow host
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rd_data <= `ZVSCFG_READ_ZERO;
         rd_valid <= 1'b0;
      end
      else
      begin
         rd_data <= next_rd_data;
         rd_valid <= next_rd_valid;
      end
   end

endmodule : zvscfg_bank

`default_nettype wire

// ### sim/zvscfg_bank_checker.sv
// Concurrent checks on the soft-switching config and read-back bank
`timescale 1ns/1ps
`default_nettype none
module zvscfg_bank_checker
(
   input wire logic clock,
   input wire logic rst_b,
   input wire logic wr_en,
   input wire logic [7:0] wr_addr,
   input wire logic [15:0] wr_data,
   input wire logic rd_en,
   input wire logic [15:0] rd_data,
   input wire logic rd_valid,
   input wire logic fault_event,
   input wire logic fault_response_disabled,
   input wire logic restart_conditions,
   input wire logic forward_valley,
   input wire logic rectifier_soft_switch_mode,
   input wire logic soft_switch_drive,
   input wire logic bus_switch_enable,
   input wire logic internal_reset,
   input wire logic auto_restart
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);
   // Decoded causes; only 0x3E may move the config
   wire logic cfg_wr = wr_en && wr_addr == 8'h3E;
   wire logic hit = fault_event && fault_response_disabled;
   sequence drop_s;
      internal_reset && !bus_switch_enable;
   endsequence
   sequence calm_s;
      !internal_reset && !auto_restart && !bus_switch_enable;
   endsequence
   fwd_cfg_a: assert property (
      cfg_wr |=> forward_valley == $past(wr_data[11]))
      else $error("forward valley not taken from config write");
   soft_cfg_a: assert property (
      cfg_wr |=> rectifier_soft_switch_mode == $past(wr_data[10]))
      else $error("soft mode not taken from config write");
   cfg_hold_a: assert property (
      !cfg_wr |=> $stable(forward_valley) && $stable(rectifier_soft_switch_mode))
      else $error("config moved without a config write");
   soft_off_a: assert property (
      !rectifier_soft_switch_mode |=> !soft_switch_drive)
      else $error("drive active with soft mode off");
   rd_answer_a: assert property (
      rd_en |=> rd_valid)
      else $error("read not answered next cycle");
   rd_cause_a: assert property (
      rd_valid |-> $past(rd_en))
      else $error("read valid without a read");
   rd_hold_a: assert property (
      !rd_en |=> $stable(rd_data))
      else $error("read data moved without a read");
   fault_drop_a: assert property (
      hit |=> drop_s ##1 calm_s)
      else $error("fault drop or reset pulse wrong");
   restart_req_a: assert property (
      hit |=> auto_restart == $past(restart_conditions))
      else $error("auto restart does not follow conditions");
   no_fault_a: assert property (
      !hit |=> !internal_reset && !auto_restart)
      else $error("reset pulse without a disabled-response fault");
endmodule : zvscfg_bank_checker
bind zvscfg_bank zvscfg_bank_checker i_zvscfg_bank_checker (.clock, .rst_b,
   .wr_en, .wr_addr, .wr_data, .rd_en, .rd_data, .rd_valid, .fault_event,
   .fault_response_disabled, .restart_conditions, .forward_valley,
   .rectifier_soft_switch_mode, .soft_switch_drive, .bus_switch_enable,
   .internal_reset, .auto_restart);
`default_nettype wire

// ### sim/zvscfg_host_model.sv
// Bus host model driving the register port of the bank
`timescale 1ns/1ps
`default_nettype none
module zvscfg_host_model
(
   input wire logic clock,
   output logic wr_en,
   output logic [7:0] wr_addr,
   output logic [15:0] wr_data,
   output logic rd_en,
   output logic [7:0] rd_addr,
   input wire logic [15:0] rd_data,
   input wire logic rd_valid
);
   initial
   begin
      {wr_en, rd_en, wr_addr, rd_addr, wr_data} = 34'h0;
   end
   // Released data shows the inverse so stale values never pass
   task automatic write_word(input logic [7:0] a, input logic [15:0] d);
      @(posedge clock);
      {wr_en, wr_addr, wr_data} <= {1'b1, a, d};
      @(posedge clock);
      {wr_en, wr_addr, wr_data} <= {1'b0, ~a, ~d};
   endtask : write_word
   task automatic read_word(input logic [7:0] a, output logic [15:0] v,
      output logic ok);
      @(posedge clock);
      {rd_en, rd_addr} <= {1'b1, a};
      @(posedge clock);
      {rd_en, rd_addr} <= {1'b0, ~a};
      #1;
      v = rd_data;
      ok = rd_valid;
   endtask : read_word
   // Power-on writes zero to offset 0x86, which the bank does not decode
   task automatic power_on;
      write_word(8'h86, 16'h0000);
   endtask : power_on
endmodule : zvscfg_host_model
`default_nettype wire

// ### sim/zvscfg_bank_tb_top.sv
// Self-checking bench for the soft-switching config and read-back bank
`timescale 1ns/1ps
`default_nettype none
module zvscfg_bank_tb_top;
   logic clock, rst_b, wr_en, rd_en, rd_valid, ok;
   logic [7:0] wr_addr, rd_addr, current_setpoint_field, measured_current;
   logic [15:0] wr_data, rd_data, v;
   logic [11:0] voltage_setpoint_field, overvoltage_threshold_field;
   logic [11:0] undervoltage_threshold_field, measured_voltage;
   logic [8:0] power_limit_field;
   logic [1:0] overvoltage_action, undervoltage_action, output_short_action;
   logic [1:0] sense_pin_short_action, undervoltage_timeout, watchdog_timeout;
   logic [1:0] voltage_only_action, voltage_only_timer;
   logic bus_switch_enable_bit, bleeder_bit, supply_off_bit, fast_setpoint_bit;
   logic voltage_only_bit, thermal_hysteresis_bit, fault_event, valley_trigger;
   logic [3:0] cable_drop_comp_field;
   logic fault_response_disabled, restart_conditions, forward_valley;
   logic rectifier_soft_switch_mode, soft_switch_drive, bus_switch_enable;
   logic internal_reset, auto_restart;
   int err_count, n_compared, cyc, r0, w0, r1, w1;
   logic [15:0] r0_tab [4] = '{16'h0800, 16'h0400, 16'h0CE3, 16'h0000};
   zvscfg_bank i_zvscfg_bank (.clock, .rst_b, .wr_en, .wr_addr, .wr_data,
      .rd_en, .rd_addr, .rd_data, .rd_valid, .voltage_setpoint_field,
      .current_setpoint_field, .overvoltage_threshold_field,
      .undervoltage_threshold_field, .power_limit_field, .overvoltage_action,
      .undervoltage_action, .output_short_action, .sense_pin_short_action,
      .undervoltage_timeout, .watchdog_timeout, .voltage_only_action,
      .voltage_only_timer, .bus_switch_enable_bit, .bleeder_bit,
      .supply_off_bit, .fast_setpoint_bit, .voltage_only_bit,
      .thermal_hysteresis_bit, .cable_drop_comp_field, .measured_current,
      .measured_voltage, .fault_event, .fault_response_disabled,
      .restart_conditions, .valley_trigger, .forward_valley,
      .rectifier_soft_switch_mode, .soft_switch_drive, .bus_switch_enable,
      .internal_reset, .auto_restart);
   zvscfg_host_model i_zvscfg_host (.clock, .wr_en, .wr_addr, .wr_data,
      .rd_en, .rd_addr, .rd_data, .rd_valid);
   // ----------------------------------------------------------------
   // Clock, timeout and reporting
   // ----------------------------------------------------------------
   initial
   begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   // Whole run needs under 5000 cycles; ceiling leaves wide margin
   always @(posedge clock)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         err_count++;
         give_verdict();
      end
   end
   task automatic check(input string what, input logic [15:0] seen,
      input logic [15:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic give_verdict;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : give_verdict
   // Odd parity per byte: the parity bit makes the byte's ones count odd
   function automatic logic [15:0] pw(input logic [11:0] x);
      return {~^x[11:7], 2'b00, x[11:7], ~^x[6:0], x[6:0]};
   endfunction : pw
   function automatic logic [15:0] expect_word(input logic [7:0] a);
      case (a)
         8'h02: return pw(voltage_setpoint_field);
         8'h04: return pw({4'h0, current_setpoint_field});
         8'h06: return pw(overvoltage_threshold_field);
         8'h08: return pw(undervoltage_threshold_field);
         8'h0A: return {7'h00, power_limit_field};
         8'h0C: return {overvoltage_action, undervoltage_action,
            output_short_action, sense_pin_short_action, undervoltage_timeout,
            watchdog_timeout, voltage_only_action, voltage_only_timer};
         8'h0E: return {1'b0, bus_switch_enable_bit, bleeder_bit,
            supply_off_bit, fast_setpoint_bit, voltage_only_bit,
            thermal_hysteresis_bit, 5'h00, cable_drop_comp_field};
         8'h10: return pw({4'h0, measured_current});
         8'h12: return {4'h0, measured_voltage};
         default: return 16'h0000;
      endcase
   endfunction : expect_word
   // Soft-switch run: cycles from trigger to drive, then drive width
   task automatic zvs_run(input logic m, input logic [2:0] d,
      input logic [4:0] n, output int r, output int w);
      i_zvscfg_host.write_word(8'h3E, {5'h00, m, 2'b00, d, n});
      @(posedge clock);
      valley_trigger <= 1'b1;
      @(posedge clock);
      valley_trigger <= 1'b0;
      r = 0;
      w = 0;
      while (soft_switch_drive !== 1'b1 && r < 500)
      begin
         @(negedge clock);
         r++;
      end
      while (soft_switch_drive === 1'b1 && w < 1000)
      begin
         @(negedge clock);
         w++;
      end
   endtask : zvs_run
   task automatic pulse_fault(input logic dis, input logic rc);
      @(posedge clock);
      {fault_response_disabled, restart_conditions, fault_event} <= {dis, rc, 1'b1};
      @(posedge clock);
      fault_event <= 1'b0;
      @(negedge clock);
   endtask : pulse_fault
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial
   begin
      rst_b = 1'b0;
      {voltage_setpoint_field, current_setpoint_field} = 20'hABCA5;
      {overvoltage_threshold_field, undervoltage_threshold_field} = 24'h5A30FF;
      {power_limit_field, cable_drop_comp_field} = 13'h1C39;
      {overvoltage_action, undervoltage_action, output_short_action,
         sense_pin_short_action, undervoltage_timeout, watchdog_timeout,
         voltage_only_action, voltage_only_timer} = 16'h1B1E;
      {bus_switch_enable_bit, bleeder_bit, supply_off_bit, fast_setpoint_bit,
         voltage_only_bit, thermal_hysteresis_bit} = 6'h1B;
      {measured_current, measured_voltage} = 20'h96C35;
      {fault_event, fault_response_disabled, restart_conditions} = 3'h0;
      valley_trigger = 1'b0;
      repeat (4) @(posedge clock);
      rst_b <= 1'b1;
      i_zvscfg_host.power_on();
      // Config bits: each enable alone, both, none, each followed by an ignored write to 0x3C
      foreach (r0_tab[i])
      begin
         i_zvscfg_host.write_word(8'h3E, r0_tab[i]);
         i_zvscfg_host.write_word(8'h3C, ~r0_tab[i]);
         @(negedge clock);
         check("forward_valley", 16'(forward_valley), 16'(r0_tab[i][11]));
         check("soft_mode", 16'(rectifier_soft_switch_mode), 16'(r0_tab[i][10]));
      end
      $display("test config done");
      // Offsets 0x00 to 0x40, two opposite patterns; odd offsets and 0x3E read zero
      for (int p = 0; p < 2; p++)
      begin
         for (int a = 0; a < 65; a++)
         begin
            i_zvscfg_host.read_word(8'(a), v, ok);
            check("rd_valid", 16'(ok), 16'h0001);
            check($sformatf("word %h", a), v, expect_word(8'(a)));
         end
         @(posedge clock);
         {voltage_setpoint_field, current_setpoint_field,
            overvoltage_threshold_field, undervoltage_threshold_field,
            power_limit_field, cable_drop_comp_field, measured_current,
            measured_voltage, bleeder_bit, supply_off_bit} <=
            ~{voltage_setpoint_field, current_setpoint_field,
            overvoltage_threshold_field, undervoltage_threshold_field,
            power_limit_field, cable_drop_comp_field, measured_current,
            measured_voltage, bleeder_bit, supply_off_bit};
      end
      $display("test readback done");
      // Counts of three and up; mode off ignores the trigger
      zvs_run(1'b0, 3'd3, 5'd3, r0, w0);
      check("drive_mode_off", 16'(r0), 16'd500);
      zvs_run(1'b1, 3'd3, 5'd3, r0, w0);
      zvs_run(1'b1, 3'd4, 5'd3, r1, w1);
      check("delay_step", 16'(r1 - r0), 16'd17);
      check("width_same", 16'(w1), 16'(w0));
      zvs_run(1'b1, 3'd3, 5'd4, r1, w1);
      check("on_step", 16'(w1 - w0), 16'd17);
      $display("test soft switch done");
      // Fault drop, restart request and clearing of the drop
      @(posedge clock);
      bus_switch_enable_bit <= 1'b1;
      repeat (2) @(posedge clock);
      @(negedge clock);
      check("bus_on", 16'(bus_switch_enable), 16'h0001);
      pulse_fault(1'b1, 1'b1);
      check("reset_pulse", 16'(internal_reset), 16'h0001);
      check("restart", 16'(auto_restart), 16'h0001);
      check("bus_drop", 16'(bus_switch_enable), 16'h0000);
      pulse_fault(1'b1, 1'b0);
      check("restart_off", 16'(auto_restart), 16'h0000);
      check("bus_held", 16'(bus_switch_enable), 16'h0000);
      pulse_fault(1'b0, 1'b1);
      check("enabled_resp", 16'(internal_reset), 16'h0000);
      @(posedge clock);
      bus_switch_enable_bit <= 1'b0;
      repeat (2) @(posedge clock);
      bus_switch_enable_bit <= 1'b1;
      repeat (2) @(posedge clock);
      pulse_fault(1'b0, 1'b1);
      check("bus_back", 16'(bus_switch_enable), 16'h0001);
      $display("test fault done");
      give_verdict();
   end
endmodule : zvscfg_bank_tb_top
`default_nettype wire
